//--- dv/backlight_zone_current_regs_tb.sv
// Self-checking bench for the zone current register bank.
// Assumes the package, interface and design sources are compiled first.
`default_nettype none
`include "backlight_zone_current_regs.svh"

module backlight_zone_current_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import backlight_zone_pkg::*;

    localparam logic [6:0] dev_addr   = 7'h35; // Arbitrary value
    localparam int         max_cycles = 20000;

    typedef struct {
        logic [1:0] kind;
        logic [7:0] value;
    } note_type;

    logic       clk, reset_n, scl, sda_in, sda_out, sda_oe;
    logic       dim_timeout, dim_enable, dim_active, led_look, rx_valid;
    zone_type   zone_select;
    code_type   led_code;
    logic [7:0] rx_byte;
    logic [7:0] model [4];
    logic [7:0] buf_data [4];
    note_type   note_q [$];
    note_type   nt;
    int         n_mismatch, cmp_count, cycles;

    backlight_zone_current_regs #(.DEV_ADDR(dev_addr)) i_backlight_zone_current_regs (
        .clk(clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .zone_select(zone_select), .dim_timeout(dim_timeout),
        .dim_enable(dim_enable), .led_code(led_code), .dim_active(dim_active));

    i2c_host_model i_i2c_host_model (.clk(clk), .sda_oe(sda_oe), .scl(scl),
        .sda_in(sda_in), .rx_byte(rx_byte), .rx_valid(rx_valid));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (note_q.size() != 0) n_mismatch++;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cycles++;
        if (cycles == max_cycles) begin
            n_mismatch++;
            $display("BAD t=%0t run did not finish", $time);
            tally_and_finish();
        end
    end

    // Watcher: each result that appears takes the oldest note
    always @(posedge clk) begin
        if ((rx_valid === 1'b1 || led_look === 1'b1) && note_q.size() == 0) begin
            n_mismatch++;
            $display("BAD t=%0t result with no expectation", $time);
        end else if (rx_valid === 1'b1 || led_look === 1'b1) begin
            nt = note_q.pop_front();
            case (nt.kind)
                2'd0: check(rx_byte, nt.value);
                2'd1: check(rx_byte, nt.value);
                default: check({dim_active, led_code}, nt.value);
            endcase
        end
    end

    function automatic logic is_code_addr(input logic [7:0] a);
        return a >= `BRIGHT_MAX_ADDR && a <= `OFFICE_DIM_ADDR;
    endfunction : is_code_addr

    task automatic note(input logic [1:0] kind, input logic [7:0] value);
        note_type n;
        n.kind  = kind;
        n.value = value;
        note_q.push_back(n);
    endtask : note

    task automatic send(input logic [7:0] b, input logic exp_ack);
        note(2'd0, {7'h00, exp_ack});
        i_i2c_host_model.byte_io(b, 1'b0, 1'b0);
    endtask : send

    // Pointer advances per byte, also past the code block where writes are dropped
    task automatic write_burst(input logic [7:0] ptr, input int n);
        logic [7:0] a;
        a = ptr;
        i_i2c_host_model.start_cond();
        send({dev_addr, 1'b0}, 1'b0);
        send(ptr, 1'b0);
        for (int i = 0; i < n; i++) begin
            send(buf_data[i], 1'b0);
            if (is_code_addr(a)) model[a[1:0]] = {1'b0, buf_data[i][6:0]};
            a++;
        end
        i_i2c_host_model.stop_cond();
    endtask : write_burst

    task automatic read_burst(input logic [7:0] ptr, input int n);
        logic [7:0] a;
        a = ptr;
        i_i2c_host_model.start_cond();
        send({dev_addr, 1'b0}, 1'b0);
        send(ptr, 1'b0);
        i_i2c_host_model.start_cond();
        send({dev_addr, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            note(2'd1, is_code_addr(a) ? model[a[1:0]] : 8'h00);
            i_i2c_host_model.byte_io(8'hFF, 1'b1, i == n - 1);
            a++;
        end
        i_i2c_host_model.stop_cond();
    endtask : read_burst

    // sel = {zone, timeout, enable}; model index is {zone, dim}
    task automatic dim_case(input logic [2:0] sel);
        logic dim;
        zone_select <= zone_type'(sel[2]);
        dim_timeout <= sel[1];
        dim_enable  <= sel[0];
        repeat (2) @(posedge clk);
        dim = sel[1] | sel[0];
        note(2'd2, {dim, model[{sel[2], dim}][6:0]});
        led_look <= 1'b1;
        @(posedge clk);
        led_look <= 1'b0;
    endtask : dim_case

    initial begin
        reset_n     = 1'b0;
        zone_select = ZONE_BRIGHT;
        dim_timeout = 1'b0;
        dim_enable  = 1'b0;
        led_look    = 1'b0;
        n_mismatch  = 0;
        cmp_count   = 0;
        cycles      = 0;
        model       = '{default: 8'h00};
        void'($urandom(32'h17bfaff3));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        read_burst(8'h0C, 4);
        dim_case(3'b000);
        // Boundary codes, reserved bit set in two of them
        buf_data = '{8'hFF, 8'h80, 8'h7F, 8'h01};
        write_burst(8'h0C, 4);
        read_burst(8'h0C, 4);
        for (int k = 0; k < 8; k++) dim_case(3'(k));
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 4; i++) buf_data[i] = 8'($urandom());
            write_burst(8'h0D + 8'(r), 4);
            read_burst(8'h0B + 8'(r), 4);
            dim_case(3'($urandom()));
        end
        // A foreign device address gets no ack and changes nothing
        i_i2c_host_model.start_cond();
        send({dev_addr ^ 7'h01, 1'b0}, 1'b1);
        i_i2c_host_model.stop_cond();
        read_burst(8'h0C, 4);
        // Reset in mid-run clears all four codes
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        model = '{default: 8'h00};
        @(posedge clk);
        read_burst(8'h0C, 4);
        dim_case(3'b111);
        repeat (4) @(posedge clk);
        // Open-drain data value must never be driven high
        check({7'h00, sda_out}, 8'h00);
        tally_and_finish();
    end
endmodule : backlight_zone_current_regs_tb

`default_nettype wire

//--- dv/i2c_host_model.sv
// Behavioural serial host: drives the clock line and shares the data line.
// Assumes the device pulls the data line low through sda_oe; the line has a pull-up.
`default_nettype none

module i2c_host_model (
    input  wire logic  clk,
    input  wire logic  sda_oe,
    output logic       scl,
    output logic       sda_in,
    output logic [7:0] rx_byte,
    output logic       rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    logic host_low;

    // Pull-up: low whenever either party pulls, so a released line reads high
    assign sda_in = !(host_low || sda_oe);

    initial begin
        scl      = 1'b1;
        host_low = 1'b0;
        rx_byte  = 8'h00;
        rx_valid = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    // Data moves only while the clock line is low; sampled half a clock before the clock line falls
    task automatic bit_io(input logic tx, output logic rx);
        host_low <= !tx;
        wait_clk(2);
        scl <= 1'b1;
        wait_clk(4);
        @(negedge clk);
        rx = sda_in;
        @(posedge clk);
        scl <= 1'b0;
        wait_clk(2);
    endtask : bit_io

    task automatic start_cond();
        host_low <= 1'b0;
        wait_clk(2);
        scl <= 1'b1;
        wait_clk(4);
        host_low <= 1'b1;
        wait_clk(4);
        scl <= 1'b0;
        wait_clk(2);
    endtask : start_cond

    task automatic stop_cond();
        host_low <= 1'b1;
        wait_clk(2);
        scl <= 1'b1;
        wait_clk(4);
        host_low <= 1'b0;
        wait_clk(4);
    endtask : stop_cond

    // Write: reports the ack bit; read: sends host_ack after the byte, then reports the byte
    task automatic byte_io(input logic [7:0] tx, input logic rd, input logic host_ack);
        logic [7:0] d;
        logic       a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(rd || tx[i], d[i]);
        end
        bit_io(rd ? host_ack : 1'b1, a);
        rx_byte  <= rd ? d : {7'h00, a};
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask : byte_io
endmodule : i2c_host_model

`default_nettype wire

//--- src/backlight_zone_current_regs.sv
// Serial control slave and dim selection for the bright and office zone currents.
// Assumes scl and sda_in are already synchronous to clk; sda is open drain.
`default_nettype none
`include "backlight_zone_current_regs.svh"

module backlight_zone_current_regs #(
    parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT // Arbitrary value
) (
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire logic                         scl,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe,
    input  wire backlight_zone_pkg::zone_type zone_select,
    input  wire logic                         dim_timeout,
    input  wire logic                         dim_enable,
    output backlight_zone_pkg::code_type      led_code,
    output logic                              dim_active
);
    import backlight_zone_pkg::*;

    zone_store_if bus ();

    zone_code_store u_store (
        .clk     (clk),
        .reset_n (reset_n),
        .bus     (bus)
    );

    state_type  state_reg;
    state_type  state_next;
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic       acked_reg;
    logic       acked_next;
    logic       wr_en_reg;
    logic       wr_en_next;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_addr_next;
    logic [7:0] wr_data_reg;
    logic [7:0] wr_data_next;
    logic       sda_oe_reg;
    logic       sda_oe_next;
    logic       scl_reg;
    logic       sda_reg;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;

    assign scl_rise   = scl && !scl_reg;
    assign scl_fall   = !scl && scl_reg;
    assign start_seen = scl && scl_reg && sda_reg && !sda_in;
    assign stop_seen  = scl && scl_reg && !sda_reg && sda_in;

    always_comb begin
        state_next   = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next   = shift_reg;
        tx_next      = tx_reg;
        ptr_next     = ptr_reg;
        acked_next   = acked_reg;
        wr_en_next   = 1'b0;
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        if (start_seen) begin
            state_next   = ST_DEV;
            bit_cnt_next = 4'h0;
        end else if (stop_seen) begin
            state_next = ST_IDLE;
        end else if (scl_rise) begin
            case (state_reg)
                ST_DEV, ST_PTR, ST_WDATA: begin
                    shift_next   = {shift_reg[6:0], sda_in};
                    bit_cnt_next = bit_cnt_reg + 4'h1;
                end
                ST_RDATA_ACK: acked_next = !sda_in;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                ST_DEV: begin
                    if (bit_cnt_reg == 4'h8) begin
                        // A different device address drops out until the next start
                        state_next = (shift_reg[7:1] == DEV_ADDR) ? ST_DEV_ACK : ST_IDLE;
                    end
                end
                ST_DEV_ACK: begin
                    bit_cnt_next = 4'h0;
                    if (shift_reg[0]) begin
                        state_next = ST_RDATA;
                        tx_next    = bus.rd_data;
                    end else begin
                        state_next = ST_PTR;
                    end
                end
                ST_PTR: begin
                    if (bit_cnt_reg == 4'h8) begin
                        state_next = ST_PTR_ACK;
                        ptr_next   = shift_reg;
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK: begin
                    state_next   = ST_WDATA;
                    bit_cnt_next = 4'h0;
                end
                ST_WDATA: begin
                    if (bit_cnt_reg == 4'h8) begin
                        // Every byte is acknowledged; unmapped pointers just store nothing
                        state_next   = ST_WDATA_ACK;
                        wr_en_next   = 1'b1;
                        wr_addr_next = ptr_reg;
                        wr_data_next = shift_reg;
                        ptr_next     = ptr_reg + 8'h01;
                    end
                end
                ST_RDATA: begin
                    if (bit_cnt_reg == 4'h7) begin
                        state_next = ST_RDATA_ACK;
                        acked_next = 1'b0;
                        ptr_next   = ptr_reg + 8'h01;
                    end else begin
                        tx_next      = {tx_reg[6:0], 1'b0};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                end
                ST_RDATA_ACK: begin
                    // The read pointer moved many cycles ago, so rd_data is settled
                    bit_cnt_next = 4'h0;
                    tx_next      = bus.rd_data;
                    state_next   = acked_reg ? ST_RDATA : ST_IDLE;
                end
                default: state_next = ST_IDLE;
            endcase
        end
        case (state_next)
            ST_DEV_ACK, ST_PTR_ACK, ST_WDATA_ACK: sda_oe_next = 1'b1;
            ST_RDATA: sda_oe_next = !tx_next[7];
            default: sda_oe_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            tx_reg      <= 8'h00;
            ptr_reg     <= 8'h00;
            acked_reg   <= 1'b0;
            wr_en_reg   <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            sda_oe_reg  <= 1'b0;
            scl_reg     <= 1'b1;
            sda_reg     <= 1'b1;
        end else begin
            state_reg   <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg   <= shift_next;
            tx_reg      <= tx_next;
            ptr_reg     <= ptr_next;
            acked_reg   <= acked_next;
            wr_en_reg   <= wr_en_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
            sda_oe_reg  <= sda_oe_next;
            scl_reg     <= scl;
            sda_reg     <= sda_in;
        end
    end

    assign bus.wr_en   = wr_en_reg;
    assign bus.wr_addr = wr_addr_reg;
    assign bus.wr_data = wr_data_reg;
    assign bus.rd_addr = ptr_reg;
    assign sda_out     = 1'b0;
    assign sda_oe      = sda_oe_reg;

    code_type led_code_reg;
    code_type led_code_next;
    logic     dim_active_reg;
    logic     dim_active_next;

    always_comb begin
        dim_active_next = dim_timeout || dim_enable;
        if (zone_select == ZONE_OFFICE) begin
            led_code_next = dim_active_next ? bus.office_dim : bus.office_max;
        end else begin
            led_code_next = dim_active_next ? bus.bright_dim : bus.bright_max;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            led_code_reg   <= `CODE_RESET;
            dim_active_reg <= 1'b0;
        end else begin
            led_code_reg   <= led_code_next;
            dim_active_reg <= dim_active_next;
        end
    end

    assign led_code   = led_code_reg;
    assign dim_active = dim_active_reg;

    a_bright_max_write: assert property (@(posedge clk) disable iff (!reset_n)
        bus.wr_en && bus.wr_addr == `BRIGHT_MAX_ADDR
        |=> bus.bright_max == $past(bus.wr_data[6:0]))
        else $error("bright max code not stored");
    a_bright_dim_write: assert property (@(posedge clk) disable iff (!reset_n)
        bus.wr_en && bus.wr_addr == `BRIGHT_DIM_ADDR
        |=> bus.bright_dim == $past(bus.wr_data[6:0]))
        else $error("bright dim code not stored");
    a_dim_output_select: assert property (@(posedge clk) disable iff (!reset_n)
        (dim_enable || dim_timeout) && zone_select == ZONE_BRIGHT
        |=> dim_active && led_code == $past(bus.bright_dim))
        else $error("dim code not applied");
    a_max_output_select: assert property (@(posedge clk) disable iff (!reset_n)
        !dim_enable && !dim_timeout && zone_select == ZONE_OFFICE
        |=> !dim_active && led_code == $past(bus.office_max))
        else $error("max code not applied");
    a_write_lands_code: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == ST_WDATA && scl_fall && bit_cnt_reg == 4'h8 && !start_seen && !stop_seen
        && ptr_reg == `BRIGHT_MAX_ADDR
        |=> ##1 bus.bright_max == $past(shift_reg[6:0], 2))
        else $error("serial write did not reach the code");

    c_write_strobe: cover property (@(posedge clk) disable iff (!reset_n) bus.wr_en);
    c_read_byte: cover property (@(posedge clk) disable iff (!reset_n)
        state_reg == ST_RDATA ##1 state_reg == ST_RDATA_ACK);
    c_dim_on: cover property (@(posedge clk) disable iff (!reset_n) $rose(dim_active));

endmodule : backlight_zone_current_regs

`default_nettype wire

//--- src/backlight_zone_current_regs.svh
// Register map constants for the bright and office zone current settings.
// Assumes an 8-bit register pointer on the serial control interface.
`ifndef BACKLIGHT_ZONE_CURRENT_REGS_SVH
`define BACKLIGHT_ZONE_CURRENT_REGS_SVH

`define BRIGHT_MAX_ADDR   8'h0C
`define BRIGHT_DIM_ADDR   8'h0D
`define OFFICE_MAX_ADDR   8'h0E
`define OFFICE_DIM_ADDR   8'h0F
`define ZONE_BLOCK_BASE   6'h03
`define CODE_MSB          6
`define CODE_LSB          0
`define RESERVED_BIT      7
`define CODE_RESET        7'h00
`define CODE_FULL_SCALE   7'h7F
`define DEV_ADDR_DEFAULT  7'h2B

`endif

//--- src/backlight_zone_pkg.sv
// Types and shared decode for the zone current register bank.
// Assumes backlight_zone_current_regs.svh is on the include path.
`default_nettype none
`include "backlight_zone_current_regs.svh"

package backlight_zone_pkg;

    typedef logic [6:0] code_type;

    typedef enum logic {
        ZONE_BRIGHT = 1'b0,
        ZONE_OFFICE = 1'b1
    } zone_type;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_DEV       = 4'h1,
        ST_DEV_ACK   = 4'h2,
        ST_PTR       = 4'h3,
        ST_PTR_ACK   = 4'h4,
        ST_WDATA     = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA     = 4'h7,
        ST_RDATA_ACK = 4'h8
    } state_type;

    function automatic logic is_mapped(input logic [7:0] addr);
        return addr[7:2] == `ZONE_BLOCK_BASE;
    endfunction : is_mapped

    function automatic logic [1:0] reg_index(input logic [7:0] addr);
        return addr[1:0];
    endfunction : reg_index

endpackage : backlight_zone_pkg

`default_nettype wire

//--- src/zone_code_store.sv
// Four 7-bit current codes with a write port and a registered read port.
// Assumes writes are single-cycle strobes from the serial front end.
`default_nettype none
`include "backlight_zone_current_regs.svh"

module zone_code_store (
    input  wire logic   clk,
    input  wire logic   reset_n,
    zone_store_if.store bus
);
    import backlight_zone_pkg::*;

    code_type   code_reg  [4];
    code_type   code_next [4];
    logic [7:0] rd_reg;
    logic [7:0] rd_next;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            code_next[i] = code_reg[i];
        end
        // Bit 7 of the write data is dropped
        if (bus.wr_en && is_mapped(bus.wr_addr)) begin
            code_next[reg_index(bus.wr_addr)] = bus.wr_data[`CODE_MSB:`CODE_LSB];
        end
        rd_next = 8'h00;
        // Unmapped pointers and the reserved bit read as zero
        if (is_mapped(bus.rd_addr)) begin
            rd_next = {1'b0, code_reg[reg_index(bus.rd_addr)]};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) begin
                code_reg[i] <= `CODE_RESET;
            end
            rd_reg <= 8'h00;
        end else begin
            code_reg <= code_next;
            rd_reg   <= rd_next;
        end
    end

    assign bus.rd_data    = rd_reg;
    assign bus.bright_max = code_reg[0];
    assign bus.bright_dim = code_reg[1];
    assign bus.office_max = code_reg[2];
    assign bus.office_dim = code_reg[3];

    a_reserved_reads_zero: assert property (@(posedge clk) disable iff (!reset_n)
        bus.rd_data[`RESERVED_BIT] == 1'b0)
        else $error("reserved bit read back as one");
    a_unmapped_reads_zero: assert property (@(posedge clk) disable iff (!reset_n)
        !is_mapped(bus.rd_addr) |=> bus.rd_data == 8'h00)
        else $error("unmapped pointer returned data");
    a_office_max_write: assert property (@(posedge clk) disable iff (!reset_n)
        bus.wr_en && bus.wr_addr == `OFFICE_MAX_ADDR
        |=> bus.office_max == $past(bus.wr_data[6:0]))
        else $error("office max code not stored");
    a_office_dim_write: assert property (@(posedge clk) disable iff (!reset_n)
        bus.wr_en && bus.wr_addr == `OFFICE_DIM_ADDR
        |=> bus.office_dim == $past(bus.wr_data[6:0]))
        else $error("office dim code not stored");

endmodule : zone_code_store

`default_nettype wire

//--- src/zone_store_if.sv
// Connection between the serial front end and the code store.
// Assumes one clock domain shared by both ends.
`default_nettype none

interface zone_store_if;
    import backlight_zone_pkg::*;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    code_type   bright_max;
    code_type   bright_dim;
    code_type   office_max;
    code_type   office_dim;

    modport front (output wr_en, wr_addr, wr_data, rd_addr,
                   input rd_data, bright_max, bright_dim, office_max, office_dim);
    modport store (input wr_en, wr_addr, wr_data, rd_addr,
                   output rd_data, bright_max, bright_dim, office_max, office_dim);
endinterface : zone_store_if

`default_nettype wire
